// ### hdl/chp_pkg.sv
// shared constants and types for the card host pin function logic
package chp_pkg;
  // interface modes of the shared pins
  typedef enum logic [1:0] {
    CHP_MODE_MEM,
    CHP_MODE_IO,
    CHP_MODE_IDE
  } chp_mode_t;
  // what a decoded access reaches inside the card
  typedef enum logic [2:0] {
    CHP_SEL_NONE,
    CHP_SEL_IO_REG,
    CHP_SEL_MEM_REG,
    CHP_SEL_CIS,
    CHP_SEL_CONFIG,
    CHP_SEL_TASK,
    CHP_SEL_CTRL
  } chp_sel_t;
  // address widths
  localparam int CHP_ADDR_W = 11;
  localparam int CHP_TASK_W = 3;
  // first attribute byte of the configuration registers
  localparam logic [10:0] CHP_CONFIG_BASE = 11'h200;
  // task file index of the 16-bit data register
  localparam logic [2:0] CHP_TASK_DATA = 3'h0;
  // idle value of the upper address lines in ide mode
  localparam logic [7:0] CHP_IDE_UPPER_IDLE = 8'h00;
  // reset values
  localparam logic CHP_RST_CHANGED = 1'b0;
  localparam logic CHP_RST_MASTER = 1'b0;
  localparam logic CHP_RST_PEER = 1'b0;
  localparam logic CHP_RST_PIN_HIGH = 1'b1;
  localparam logic [10:0] CHP_RST_ADDR = 11'h000;
endpackage : chp_pkg

// ### hdl/chp_if.sv
// pin level connection between the card and the host socket
`timescale 1ns/1ps
interface chp_if;
  import chp_pkg::*;
  logic [10:0] addr; // host address lines
  logic attr_sel_n; // attribute space select, low active
  logic task_file_select_n; // first ide chip select
  logic control_block_select_n; // second ide chip select
  logic drive_select_n; // master when low, slave when high
  logic pin45_card_o; // card drive value, shared pin 45
  logic pin45_card_oe; // card drives pin 45
  logic pin46_card_o; // card drive value, shared pin 46
  logic pin46_card_oe; // card drives pin 46
  logic pin45_host_o; // host drive value, pin 45
  logic pin45_host_oe; // host drives pin 45
  logic pin46_host_o; // host drive value, pin 46
  logic pin46_host_oe; // host drives pin 46
  logic presence_detect_one_n; // tied low on the card
  logic presence_detect_two_n; // tied low on the card
  logic pin45_lvl; // resolved level, pulled up
  logic pin46_lvl; // resolved level, pulled up
  // wired level: any driver pulling low wins, else pull-up
  assign pin45_lvl = ~((pin45_card_oe & ~pin45_card_o) | (pin45_host_oe & ~pin45_host_o));
  assign pin46_lvl = ~((pin46_card_oe & ~pin46_card_o) | (pin46_host_oe & ~pin46_host_o));
  modport card (
    input addr, attr_sel_n, task_file_select_n, control_block_select_n, drive_select_n,
    input pin45_lvl, pin46_lvl,
    output pin45_card_o, pin45_card_oe, pin46_card_o, pin46_card_oe,
    output presence_detect_one_n, presence_detect_two_n
  );
  modport host (
    output addr, attr_sel_n, task_file_select_n, control_block_select_n, drive_select_n,
    output pin45_host_o, pin45_host_oe, pin46_host_o, pin46_host_oe,
    input pin45_lvl, pin46_lvl, presence_detect_one_n, presence_detect_two_n
  );
endinterface : chp_if

// ### hdl/chp_card.sv
// card end: address decode, status pins, ide handshake pins
`timescale 1ns/1ps
// Behaviour
// - configuration registers start at attribute 200h
// - pc modes decode a10..a0 with attribute select
// - ide uses only a2..a0 for task file
// - host grounds a10..a3 in ide mode
// - memory mode pin 46 held high
// - io mode alert low on ready/protect change
// - alert enabled by config and status setting
// - memory mode pin 45 driven high always
// - io mode audio pin driven high
// - ide pin 46 is pass diagnostic handshake
// - ide pin 45 is active/slave present
// - host sees card only with both detects low
// - drive select grounded means master, open slave
// - ide selects: task file and control block
// - task file bytewise, data register 16-bit
module chp_card (
  input wire logic clk_i,
  input wire logic srst_i,
  chp_if.card pins,
  input wire chp_pkg::chp_mode_t mode_i, // current interface mode
  input wire logic ready_not_busy_i, // internal ready state
  input wire logic write_protect_i, // internal write protect state
  input wire logic change_alert_en_i, // alert enable from config and status reg
  input wire logic change_clear_i, // one-cycle clear of the change flag
  input wire logic diag_passed_i, // own diagnostic passed (slave use)
  input wire logic drive_active_i, // own drive is busy with a command
  output logic [2:0] sel_o, // decoded target, chp_sel_t code
  output logic [10:0] index_o, // register or byte index within target
  output logic word_access_o, // access uses d15..d00
  output logic change_pending_o, // sticky change of ready or protect
  output logic is_master_o, // ide master when high
  output logic peer_diag_passed_o, // master saw slave pass diagnostic
  output logic slave_present_o // master saw pin 45 low: slave present, or slave or own drive active
);
  import chp_pkg::*;

  // decode registers
  chp_sel_t sel_reg, sel_next;
  logic [10:0] index_reg, index_next;
  logic word_reg, word_next;
  // status change registers
  logic changed_reg, changed_next;
  logic rdy_prev_reg, rdy_prev_next;
  logic wp_prev_reg, wp_prev_next;
  // ide handshake registers
  logic master_reg, master_next;
  logic peer_diag_reg, peer_diag_next;
  logic peer_present_reg, peer_present_next;

  // pc card decode of attribute space, used for both pc modes
  function automatic chp_sel_t attr_decode(input logic [10:0] a);
    if (a >= CHP_CONFIG_BASE) begin
      attr_decode = CHP_SEL_CONFIG;
    end else begin
      attr_decode = CHP_SEL_CIS;
    end
  endfunction : attr_decode

  // next value of the access decode
  always_comb begin
    sel_next = CHP_SEL_NONE;
    index_next = CHP_RST_ADDR;
    word_next = 1'b0;
    case (mode_i)
      CHP_MODE_MEM, CHP_MODE_IO: begin
        // eleven lines plus attribute select
        if (!pins.attr_sel_n) begin
          sel_next = attr_decode(pins.addr);
          if (sel_next == CHP_SEL_CONFIG) begin
            index_next = pins.addr - CHP_CONFIG_BASE;
          end else begin
            index_next = pins.addr;
          end
        end else if (mode_i == CHP_MODE_IO) begin
          sel_next = CHP_SEL_IO_REG; // io mapped registers
          index_next = pins.addr;
          word_next = 1'b1;
        end else begin
          sel_next = CHP_SEL_MEM_REG; // memory mapped registers
          index_next = pins.addr;
          word_next = 1'b1;
        end
      end
      CHP_MODE_IDE: begin
        // only a2..a0 matter, upper lines ignored
        if (!pins.task_file_select_n) begin
          sel_next = CHP_SEL_TASK;
          index_next = {8'h00, pins.addr[2:0]};
          // data register moves words, others bytes
          word_next = (pins.addr[2:0] == CHP_TASK_DATA);
        end else if (!pins.control_block_select_n) begin
          sel_next = CHP_SEL_CTRL;
          index_next = {8'h00, pins.addr[2:0]};
          word_next = 1'b0;
        end else begin
          sel_next = CHP_SEL_NONE; // no chip select active
        end
      end
      default: begin
        sel_next = CHP_SEL_NONE;
      end
    endcase
  end

  // register the decode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_reg <= CHP_SEL_NONE;
      index_reg <= CHP_RST_ADDR;
      word_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      index_reg <= index_next;
      word_reg <= word_next;
    end
  end

  // next value of the sticky status change flag
  always_comb begin
    rdy_prev_next = ready_not_busy_i;
    wp_prev_next = write_protect_i;
    changed_next = changed_reg;
    if (change_clear_i) begin
      changed_next = 1'b0;
    end
    // a change in the clear cycle still sets the flag
    if ((ready_not_busy_i != rdy_prev_reg) || (write_protect_i != wp_prev_reg)) begin
      changed_next = 1'b1;
    end
  end

  // register the status change state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      changed_reg <= CHP_RST_CHANGED;
      // track the inputs in reset, so release shows no false change
      rdy_prev_reg <= rdy_prev_next;
      wp_prev_reg <= wp_prev_next;
    end else begin
      changed_reg <= changed_next;
      rdy_prev_reg <= rdy_prev_next;
      wp_prev_reg <= wp_prev_next;
    end
  end

  // next value of the ide master/slave state
  always_comb begin
    master_next = master_reg;
    peer_diag_next = CHP_RST_PEER;
    peer_present_next = CHP_RST_PEER;
    if (mode_i == CHP_MODE_IDE) begin
      master_next = !pins.drive_select_n;
      if (master_reg) begin
        // master listens for the slave on both handshake pins
        peer_diag_next = !pins.pin46_lvl;
        peer_present_next = !pins.pin45_lvl;
      end
    end
  end

  // register the handshake state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      master_reg <= CHP_RST_MASTER;
      peer_diag_reg <= CHP_RST_PEER;
      peer_present_reg <= CHP_RST_PEER;
    end else begin
      master_reg <= master_next;
      peer_diag_reg <= peer_diag_next;
      peer_present_reg <= peer_present_next;
    end
  end

  // next values of the shared pin drivers
  logic p45_o_next, p45_oe_next, p46_o_next, p46_oe_next;
  logic p45_o_reg, p45_oe_reg, p46_o_reg, p46_oe_reg;
  always_comb begin
    p45_o_next = CHP_RST_PIN_HIGH;
    p45_oe_next = 1'b0;
    p46_o_next = CHP_RST_PIN_HIGH;
    p46_oe_next = 1'b0;
    case (mode_i)
      // pin functions follow the mode
      CHP_MODE_MEM: begin
        p46_o_next = 1'b1; // battery level one high
        p46_oe_next = 1'b1;
        p45_o_next = 1'b1; // battery level two high
        p45_oe_next = 1'b1;
      end
      CHP_MODE_IO: begin
        p45_o_next = 1'b1; // audio not provided
        p45_oe_next = 1'b1;
        // alert low while a gated change is pending
        p46_o_next = !(changed_reg && change_alert_en_i);
        p46_oe_next = 1'b1;
      end
      CHP_MODE_IDE: begin
        // open drain: drive only the low level
        p45_o_next = 1'b0;
        p46_o_next = 1'b0;
        if (master_reg) begin
          p45_oe_next = drive_active_i;
        end else begin
          p45_oe_next = 1'b1; // slave present, also when active
          p46_oe_next = diag_passed_i;
        end
      end
      default: begin
        p45_oe_next = 1'b0;
      end
    endcase
  end

  // register the pin drivers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      p45_o_reg <= CHP_RST_PIN_HIGH;
      p45_oe_reg <= 1'b0;
      p46_o_reg <= CHP_RST_PIN_HIGH;
      p46_oe_reg <= 1'b0;
    end else begin
      p45_o_reg <= p45_o_next;
      p45_oe_reg <= p45_oe_next;
      p46_o_reg <= p46_o_next;
      p46_oe_reg <= p46_oe_next;
    end
  end

  // pin and user side outputs
  assign pins.pin45_card_o = p45_o_reg;
  assign pins.pin45_card_oe = p45_oe_reg;
  assign pins.pin46_card_o = p46_o_reg;
  assign pins.pin46_card_oe = p46_oe_reg;
  assign pins.presence_detect_one_n = 1'b0; // grounded in every mode
  assign pins.presence_detect_two_n = 1'b0;
  assign sel_o = sel_reg;
  assign index_o = index_reg;
  assign word_access_o = word_reg;
  assign change_pending_o = changed_reg;
  assign is_master_o = master_reg;
  assign peer_diag_passed_o = peer_diag_reg;
  assign slave_present_o = peer_present_reg;
endmodule : chp_card

// ### hdl/chp_host.sv
// host end: address and selects out, status and handshake pins in
`timescale 1ns/1ps
module chp_host (
  input wire logic clk_i,
  input wire logic srst_i,
  chp_if.host pins,
  input wire chp_pkg::chp_mode_t mode_i, // mode the socket runs in
  input wire logic [10:0] addr_i, // requested address
  input wire logic attr_i, // request attribute space
  input wire logic task_sel_i, // ide task file access
  input wire logic ctrl_sel_i, // ide control block access
  input wire logic make_master_i, // ground drive select
  input wire logic peer_diag_i, // emulated other drive passed diagnostic
  input wire logic peer_active_i, // emulated other drive active or present
  output logic card_inserted_o, // both detects low
  output logic status_change_o, // io mode alert seen low
  output logic battery_ok_o, // memory mode both battery pins high
  output logic pin45_level_o, // sampled pin 45 level
  output logic pin46_level_o // sampled pin 46 level
);
  import chp_pkg::*;

  logic [10:0] addr_reg, addr_next; // address lines driven
  logic attr_n_reg, attr_n_next; // attribute select driven
  logic tf_n_reg, tf_n_next; // task file select driven
  logic cb_n_reg, cb_n_next; // control block select driven
  logic dsel_n_reg, dsel_n_next; // drive select driven
  logic d45_reg, d45_next; // low drive on pin 45
  logic d46_reg, d46_next; // low drive on pin 46
  logic ins_reg, ins_next; // card inserted
  logic chg_reg, chg_next; // alert seen
  logic bat_reg, bat_next; // battery pins high
  logic l45_reg, l45_next; // pin 45 sample
  logic l46_reg, l46_next; // pin 46 sample

  // next values of the socket outputs and samples
  always_comb begin
    addr_next = addr_i;
    attr_n_next = !attr_i;
    tf_n_next = 1'b1;
    cb_n_next = 1'b1;
    dsel_n_next = 1'b0; // pc modes: held grounded, never floating
    d45_next = 1'b0;
    d46_next = 1'b0;
    if (mode_i == CHP_MODE_IDE) begin
      addr_next = {CHP_IDE_UPPER_IDLE, addr_i[2:0]}; // upper lines grounded
      attr_n_next = 1'b1;
      tf_n_next = !task_sel_i;
      cb_n_next = !(ctrl_sel_i && !task_sel_i);
      dsel_n_next = !make_master_i;
      d46_next = peer_diag_i;
      d45_next = peer_active_i;
    end
    ins_next = !pins.presence_detect_one_n && !pins.presence_detect_two_n;
    chg_next = (mode_i == CHP_MODE_IO) && !pins.pin46_lvl;
    bat_next = (mode_i == CHP_MODE_MEM) && pins.pin45_lvl && pins.pin46_lvl;
    l45_next = pins.pin45_lvl;
    l46_next = pins.pin46_lvl;
  end

  // register all host state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_reg <= CHP_RST_ADDR;
      attr_n_reg <= 1'b1;
      tf_n_reg <= 1'b1;
      cb_n_reg <= 1'b1;
      dsel_n_reg <= 1'b0;
      d45_reg <= 1'b0;
      d46_reg <= 1'b0;
      ins_reg <= 1'b0;
      chg_reg <= 1'b0;
      bat_reg <= 1'b0;
      l45_reg <= CHP_RST_PIN_HIGH;
      l46_reg <= CHP_RST_PIN_HIGH;
    end else begin
      addr_reg <= addr_next;
      attr_n_reg <= attr_n_next;
      tf_n_reg <= tf_n_next;
      cb_n_reg <= cb_n_next;
      dsel_n_reg <= dsel_n_next;
      d45_reg <= d45_next;
      d46_reg <= d46_next;
      ins_reg <= ins_next;
      chg_reg <= chg_next;
      bat_reg <= bat_next;
      l45_reg <= l45_next;
      l46_reg <= l46_next;
    end
  end

  // drive the socket pins, open drain on the handshake pins
  assign pins.addr = addr_reg;
  assign pins.attr_sel_n = attr_n_reg;
  assign pins.task_file_select_n = tf_n_reg;
  assign pins.control_block_select_n = cb_n_reg;
  assign pins.drive_select_n = dsel_n_reg;
  assign pins.pin45_host_o = 1'b0;
  assign pins.pin45_host_oe = d45_reg;
  assign pins.pin46_host_o = 1'b0;
  assign pins.pin46_host_oe = d46_reg;
  assign card_inserted_o = ins_reg;
  assign status_change_o = chg_reg;
  assign battery_ok_o = bat_reg;
  assign pin45_level_o = l45_reg;
  assign pin46_level_o = l46_reg;
endmodule : chp_host

// ### tb/chp_properties.sv
// concurrent checks on the pins that join the card end and the host end
`timescale 1ns/1ps
module chp_properties (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire chp_pkg::chp_mode_t mode_i,
  input wire logic [10:0] addr,
  input wire logic drive_select_n,
  input wire logic pin45_card_o,
  input wire logic pin45_card_oe,
  input wire logic pin46_card_o,
  input wire logic pin46_card_oe,
  input wire logic presence_detect_one_n,
  input wire logic presence_detect_two_n
);
  import chp_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // three edges in one mode: host and card registers have settled
  sequence s_mem3;
    (mode_i == CHP_MODE_MEM) [*3];
  endsequence
  sequence s_io3;
    (mode_i == CHP_MODE_IO) [*3];
  endsequence
  sequence s_ide3;
    (mode_i == CHP_MODE_IDE) [*3];
  endsequence
  // ide with drive select held at one level
  sequence s_master3;
    (mode_i == CHP_MODE_IDE && !drive_select_n) [*3];
  endsequence
  sequence s_slave3;
    (mode_i == CHP_MODE_IDE && drive_select_n) [*3];
  endsequence
  a_detect_tied_low: assert property (
      !presence_detect_one_n && !presence_detect_two_n)
    else $error("presence detect not low");
  a_ide_upper_ground: assert property (
      s_ide3 |-> addr[10:3] == CHP_IDE_UPPER_IDLE)
    else $error("upper address not grounded in ide mode");
  a_mem_pins_high: assert property (
      s_mem3 |-> pin45_card_oe && pin45_card_o && pin46_card_oe && pin46_card_o)
    else $error("battery pins not driven high");
  a_io_audio_high: assert property (
      s_io3 |-> pin45_card_oe && pin45_card_o)
    else $error("audio pin not driven high");
  a_ide_open_drain: assert property (
      s_ide3 |-> !(pin45_card_oe && pin45_card_o) && !(pin46_card_oe && pin46_card_o))
    else $error("ide handshake pin driven high");
  a_master_diag_free: assert property (
      s_master3 |-> !pin46_card_oe)
    else $error("master drives diagnostic pin");
  a_slave_present_low: assert property (
      s_slave3 |-> pin45_card_oe && !pin45_card_o)
    else $error("slave does not show presence");
  a_pc_select_ground: assert property (
      (mode_i != CHP_MODE_IDE) [*3] |-> !drive_select_n)
    else $error("drive select not grounded in pc mode");
endmodule : chp_properties

// ### tb/test_card_host_pin_function_logic.sv
// self-checking bench: card end and host end joined by the pin interface
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module test_card_host_pin_function_logic;
  import chp_pkg::*;
  logic clk_i = 1'b0; // 50 mhz clock
  logic srst_i = 1'b1; // synchronous reset
  chp_mode_t mode_i = CHP_MODE_MEM; // shared mode of both ends
  logic [10:0] addr_i = 11'h000; // host request address
  logic attr_i = 1'b0, task_sel_i = 1'b0, ctrl_sel_i = 1'b0; // host selects
  logic make_master_i = 1'b0, peer_diag_i = 1'b0, peer_active_i = 1'b0; // emulated peer
  logic ready_not_busy_i = 1'b1, write_protect_i = 1'b0; // card states
  logic change_alert_en_i = 1'b0, change_clear_i = 1'b0; // alert control
  logic diag_passed_i = 1'b0, drive_active_i = 1'b0; // own drive status
  logic [2:0] sel_o;
  logic [10:0] index_o;
  logic word_access_o, change_pending_o, is_master_o, peer_diag_passed_o, slave_present_o;
  logic card_inserted_o, status_change_o, battery_ok_o, pin45_level_o, pin46_level_o;
  int n_fail = 0; // mismatches
  int total_checks = 0; // comparisons made
  always #10 clk_i = ~clk_i; // 20 ns period
  chp_if pins_if ();
  chp_card u_chp_card (.clk_i(clk_i), .srst_i(srst_i), .pins(pins_if), .mode_i(mode_i),
    .ready_not_busy_i(ready_not_busy_i), .write_protect_i(write_protect_i),
    .change_alert_en_i(change_alert_en_i), .change_clear_i(change_clear_i),
    .diag_passed_i(diag_passed_i), .drive_active_i(drive_active_i), .sel_o(sel_o),
    .index_o(index_o), .word_access_o(word_access_o), .change_pending_o(change_pending_o),
    .is_master_o(is_master_o), .peer_diag_passed_o(peer_diag_passed_o),
    .slave_present_o(slave_present_o));
  chp_host u_chp_host (.clk_i(clk_i), .srst_i(srst_i), .pins(pins_if), .mode_i(mode_i),
    .addr_i(addr_i), .attr_i(attr_i), .task_sel_i(task_sel_i), .ctrl_sel_i(ctrl_sel_i),
    .make_master_i(make_master_i), .peer_diag_i(peer_diag_i), .peer_active_i(peer_active_i),
    .card_inserted_o(card_inserted_o), .status_change_o(status_change_o),
    .battery_ok_o(battery_ok_o), .pin45_level_o(pin45_level_o), .pin46_level_o(pin46_level_o));
  chp_properties u_chp_properties (.clk_i(clk_i), .srst_i(srst_i), .mode_i(mode_i),
    .addr(pins_if.addr), .drive_select_n(pins_if.drive_select_n),
    .pin45_card_o(pins_if.pin45_card_o), .pin45_card_oe(pins_if.pin45_card_oe),
    .pin46_card_o(pins_if.pin46_card_o), .pin46_card_oe(pins_if.pin46_card_oe),
    .presence_detect_one_n(pins_if.presence_detect_one_n),
    .presence_detect_two_n(pins_if.presence_detect_two_n));
  // wait whole cycles, then step past the edge so outputs are settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // one decode request through the host, judged at the card three cycles on
  task automatic dec(input chp_mode_t m, input logic at, input logic [10:0] a, input logic ts,
      input logic cs, input logic [2:0] es, input logic [10:0] ei, input logic ew,
      input logic ci);
    @(posedge clk_i);
    mode_i <= m;
    attr_i <= at;
    addr_i <= a;
    task_sel_i <= ts;
    ctrl_sel_i <= cs;
    step(3);
    `CHK("decode target", es, sel_o)
    `CHK("decode width", ew, word_access_o)
    if (ci) begin
      `CHK("decode index", ei, index_o)
    end
  endtask : dec
  // presence seen by the host
  task automatic t_presence();
    step(2);
    `CHK("card inserted", 1'b1, card_inserted_o)
    $display("done: presence");
  endtask : t_presence
  // pc and ide decode, boundaries of config base and ignored upper lines
  task automatic t_decode();
    dec(CHP_MODE_IO, 1'b1, 11'h205, 1'b0, 1'b0, 3'h4, 11'h005, 1'b0, 1'b1);
    dec(CHP_MODE_MEM, 1'b1, 11'h200, 1'b0, 1'b0, 3'h4, 11'h000, 1'b0, 1'b1);
    dec(CHP_MODE_MEM, 1'b1, 11'h1ff, 1'b0, 1'b0, 3'h3, 11'h1ff, 1'b0, 1'b1);
    dec(CHP_MODE_IO, 1'b0, 11'h010, 1'b0, 1'b0, 3'h1, 11'h010, 1'b1, 1'b1);
    dec(CHP_MODE_MEM, 1'b0, 11'h010, 1'b0, 1'b0, 3'h2, 11'h010, 1'b1, 1'b1);
    dec(CHP_MODE_IDE, 1'b0, 11'h7ff, 1'b1, 1'b0, 3'h5, 11'h007, 1'b0, 1'b1);
    dec(CHP_MODE_IDE, 1'b0, 11'h7f8, 1'b1, 1'b0, 3'h5, 11'h000, 1'b1, 1'b1);
    dec(CHP_MODE_IDE, 1'b0, 11'h006, 1'b0, 1'b1, 3'h6, 11'h006, 1'b0, 1'b1);
    dec(CHP_MODE_IDE, 1'b0, 11'h003, 1'b0, 1'b0, 3'h0, 11'h000, 1'b0, 1'b0);
    $display("done: decode");
  endtask : t_decode
  // fixed high levels in memory and io modes
  task automatic t_fixed();
    @(posedge clk_i);
    mode_i <= CHP_MODE_MEM;
    step(4);
    `CHK("battery ok", 1'b1, battery_ok_o)
    @(posedge clk_i);
    mode_i <= CHP_MODE_IO;
    step(4);
    `CHK("audio level", 1'b1, pin45_level_o)
    $display("done: fixed pins");
  endtask : t_fixed
  // alert on state change, then suppressed by the enable
  task automatic t_alert();
    @(posedge clk_i);
    mode_i <= CHP_MODE_IO;
    change_alert_en_i <= 1'b1;
    change_clear_i <= 1'b1;
    @(posedge clk_i);
    change_clear_i <= 1'b0;
    step(4);
    `CHK("alert quiet", 1'b0, status_change_o)
    @(posedge clk_i);
    write_protect_i <= 1'b1;
    step(4);
    `CHK("change flag", 1'b1, change_pending_o)
    `CHK("alert seen", 1'b1, status_change_o)
    // clear alone drops the flag
    @(posedge clk_i);
    change_clear_i <= 1'b1;
    change_alert_en_i <= 1'b0;
    @(posedge clk_i);
    change_clear_i <= 1'b0;
    step(3);
    `CHK("change cleared", 1'b0, change_pending_o)
    // change in the clear cycle: the set wins
    @(posedge clk_i);
    change_clear_i <= 1'b1;
    ready_not_busy_i <= 1'b0;
    @(posedge clk_i);
    change_clear_i <= 1'b0;
    step(4);
    `CHK("set over clear", 1'b1, change_pending_o)
    `CHK("alert masked", 1'b0, status_change_o)
    $display("done: alert");
  endtask : t_alert
  // master and slave handshake on the shared pins
  task automatic t_ide();
    @(posedge clk_i);
    mode_i <= CHP_MODE_IDE;
    make_master_i <= 1'b1;
    peer_diag_i <= 1'b1;
    peer_active_i <= 1'b1;
    step(5);
    `CHK("master", 1'b1, is_master_o)
    `CHK("peer diag", 1'b1, peer_diag_passed_o)
    `CHK("peer present", 1'b1, slave_present_o)
    @(posedge clk_i);
    peer_diag_i <= 1'b0;
    peer_active_i <= 1'b0;
    drive_active_i <= 1'b1;
    step(5);
    `CHK("peer diag off", 1'b0, peer_diag_passed_o)
    `CHK("active level", 1'b0, pin45_level_o)
    @(posedge clk_i);
    drive_active_i <= 1'b0;
    make_master_i <= 1'b0;
    diag_passed_i <= 1'b1;
    step(5);
    `CHK("slave", 1'b0, is_master_o)
    `CHK("present level", 1'b0, pin45_level_o)
    `CHK("diag level", 1'b0, pin46_level_o)
    @(posedge clk_i);
    diag_passed_i <= 1'b0;
    step(5);
    `CHK("diag released", 1'b1, pin46_level_o)
    $display("done: ide handshake");
  endtask : t_ide
  // counts, verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_presence();
    t_decode();
    t_fixed();
    t_alert();
    t_ide();
    complete_run();
  end
endmodule : test_card_host_pin_function_logic
